// ### verilog/i2c_pkg.sv
// Purpose: shared constants and types for the two-wire client register link and its host end
// Assumes: one 20 MHz clock in each end, open-drain wires resolved by the link interface
// Notes: register offsets are byte-wide client addresses, host registers are APB words
//
// What this block does
// - SDA changes only while SCL is low
// - SDA fall with SCL high starts, bus busy
// - repeated start behaves exactly like start
// - SDA rise with SCL high stops, bus free
// - whole bytes, MSB first, unlimited count
// - host makes every SCL pulse, ninth too
// - client never holds SCL low
// - receiver pulls SDA low for ack
// - SDA high through ninth pulse is nack
// - wrong client address gets no ack
// - after nack host sends stop or restart
// - write: address, pointer, data, each acked except data for 60h..69h
// - pointer increments after each written byte
// - read: pointer write, restart, read, nack, stop
// - no enables: pointer rolls FFh to 00h
// - source0 enable only: 63h wraps to 61h
// - source1 enable only: 65h wraps to 61h
// - both enables: 69h wraps to 61h
// - enables live in registers 1Ah and 1Bh
package i2c_pkg;

    // ==========================================================
    // client side
    localparam logic [6:0] CLIENT_ADDR = 7'h2c;
    localparam logic [7:0] REG_FIRST = 8'h00;
    localparam logic [7:0] REG_SOURCE_SELECT_A = 8'h1a;
    localparam logic [7:0] REG_SOURCE_SELECT_B = 8'h1b;
    localparam logic [7:0] REG_DSP_STATUS = 8'h60;
    localparam logic [7:0] REG_STATUS_COPY = 8'h61;
    localparam logic [7:0] REG_SENSOR0_HIGH = 8'h63;
    localparam logic [7:0] REG_SENSOR1_HIGH = 8'h65;
    localparam logic [7:0] REG_TIMESTAMP3 = 8'h69;
    localparam logic [7:0] REG_LAST = 8'hff;
    localparam logic [7:0] REG_STEP = 8'h01;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int WRAP_ENABLE_BIT = 7;

    // bit counter marks: pre is the falling edge that follows a start
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_PRE = 4'hf;
    localparam logic [3:0] BIT_STEP = 4'h1;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_reg = 3'b010,
        st_wdata = 3'b011,
        st_rdata = 3'b100,
        st_ignore = 3'b101
    } client_state_t;

    // ==========================================================
    // host side
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [5:0] QUARTER_LAST = 6'(QUARTER_CYCLES - 1);
    localparam logic [5:0] QUARTER_RESET = 6'h00;
    localparam logic [5:0] QUARTER_STEP = 6'h01;

    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_TXDATA = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_NACK_BIT = 3;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_NACK_BIT = 1;
    localparam int STATUS_RX_LSB = 8;

    typedef enum logic [2:0] {
        cmd_none = 3'b000,
        cmd_start = 3'b001,
        cmd_stop = 3'b010,
        cmd_write = 3'b011,
        cmd_read = 3'b100
    } host_cmd_t;

    // quarter phases of one SCL bit time
    localparam logic [1:0] PH_SETUP = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

endpackage

// ### verilog/i2c_link_if.sv
// Purpose: open-drain two-wire link joining the host end and the client end
// Assumes: both wires pulled up, any enabled driver pulls low
// Notes: the only place where wire levels are resolved
interface i2c_link_if;
    // host drivers
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    // client drivers, no clock driver at all
    logic sda_dev_o;
    logic sda_dev_oe;
    // resolved wire levels
    logic scl;
    logic sda;

    // ==========================================================
    // wired-and with pull-ups
    assign scl = scl_host_oe ? scl_host_o : 1'b1;
    assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);

    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
                  output sda_host_o, output sda_host_oe);
endinterface

// ### verilog/pin_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are slow levels compared to clk
// Notes: only the second stage may be read by logic
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and synchronised levels
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] meta;

    // ==========================================================
    // idle bus level is high, so both stages reset high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '1;
            level <= '1;
        end else begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule

// ### verilog/i2c_client_end.sv
// Purpose: client end of the two-wire link with a 256-byte register space
// Assumes: host makes every clock pulse, quarter periods far longer than the sync delay
// Notes: clock is only sampled, never driven, so no clock stretching is possible
//
// Chosen here: register access over the two-wire link.
module i2c_client_end
    import i2c_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    i2c_link_if.device link,
    // sensor side register updates
    input wire logic upd_valid,
    input wire logic [7:0] upd_addr,
    input wire logic [7:0] upd_data,
    // status toward the chip
    output logic busy,
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);
    // ==========================================================
    // pin sampling and condition detection
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;

    pin_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin({link.scl, link.sda}),
        .level({scl_s, sda_s})
    );

    // one more stage of history for edge finding
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // data only moves while clock is low, so a data edge with clock high is a condition
    assign start_seen = scl_s && scl_d && sda_d && !sda_s;
    assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;

    // ==========================================================
    // byte engine state
    client_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic host_nack;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] mem [0:255];
    logic byte_done;
    logic ack_done;
    logic addr_match;
    logic wr_ok;
    logic do_write;
    logic load_tx;
    logic wrap0;
    logic wrap1;

    assign byte_done = scl_fall && bitcnt == BIT_LAST_DATA;
    assign ack_done = scl_fall && bitcnt == BIT_ACK;
    assign addr_match = shreg[7:1] == CLIENT_ADDR;
    // sensor result space is read only, writes there are refused
    assign wr_ok = !(ptr >= REG_DSP_STATUS && ptr <= REG_TIMESTAMP3);
    assign do_write = state == st_wdata && byte_done && wr_ok && !start_seen && !stop_seen;
    assign load_tx = state == st_rdata && ack_done && !host_nack && !start_seen && !stop_seen;
    assign wrap0 = mem[REG_SOURCE_SELECT_A][WRAP_ENABLE_BIT];
    assign wrap1 = mem[REG_SOURCE_SELECT_B][WRAP_ENABLE_BIT];

    // pointer step with the sensor-data wrap windows
    function automatic logic [7:0] step_ptr(input logic [7:0] p, input logic e0, input logic e1);
        logic [7:0] last;
        last = REG_LAST;
        case ({e1, e0})
            2'b01: last = REG_SENSOR0_HIGH;
            2'b10: last = REG_SENSOR1_HIGH;
            2'b11: last = REG_TIMESTAMP3;
            default: last = REG_LAST;
        endcase
        if ((e0 || e1) && p == last) begin
            return REG_STATUS_COPY;
        end
        return 8'(p + REG_STEP);
    endfunction

    // ==========================================================
    // bit counter and receive shifter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitcnt <= BIT_PRE;
            shreg <= REG_RESET;
            host_nack <= 1'b0;
        end else if (start_seen) begin
            bitcnt <= BIT_PRE;
            host_nack <= 1'b0;
        end else if (stop_seen) begin
            bitcnt <= BIT_PRE;
        end else if (state != st_idle) begin
            if (scl_rise && bitcnt <= BIT_LAST_DATA && state != st_rdata) begin
                shreg <= {shreg[6:0], sda_s};
            end
            if (scl_rise && bitcnt == BIT_ACK && state == st_rdata) begin
                host_nack <= sda_s;
            end
            if (scl_fall) begin
                // the fall that ends a start wraps pre to bit zero
                bitcnt <= (bitcnt == BIT_ACK) ? BIT_FIRST : 4'(bitcnt + BIT_STEP);
            end
        end
    end

    // ==========================================================
    // transfer state; a start anywhere restarts address reception
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= st_idle;
        end else if (start_seen) begin
            state <= st_addr;
        end else if (stop_seen) begin
            state <= st_idle;
        end else if (byte_done) begin
            case (state)
                st_addr: begin
                    if (!addr_match) begin
                        state <= st_ignore;
                    end else if (shreg[0]) begin
                        state <= st_rdata;
                    end else begin
                        state <= st_reg;
                    end
                end
                st_reg: state <= st_wdata;
                st_wdata: state <= wr_ok ? st_wdata : st_ignore;
                default: state <= state;
            endcase
        end else if (ack_done && state == st_rdata && host_nack) begin
            state <= st_ignore;
        end
    end

    // ==========================================================
    // data pin drive; every change follows a clock fall or a start or stop, never a rise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
            tx <= REG_RESET;
        end else if (start_seen || stop_seen) begin
            sda_oe <= 1'b0;
        end else if (load_tx) begin
            tx <= mem[ptr];
            sda_oe <= !mem[ptr][7];
        end else if (byte_done) begin
            case (state)
                st_addr: sda_oe <= addr_match;
                st_reg: sda_oe <= 1'b1;
                st_wdata: sda_oe <= wr_ok;
                default: sda_oe <= 1'b0;
            endcase
        end else if (ack_done) begin
            sda_oe <= 1'b0;
        end else if (scl_fall && state == st_rdata && bitcnt < BIT_LAST_DATA) begin
            sda_oe <= !tx[6];
            tx <= {tx[6:0], 1'b0};
        end
    end

    // ==========================================================
    // register pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr <= REG_RESET;
        end else if (state == st_reg && byte_done && !start_seen && !stop_seen) begin
            ptr <= shreg;
        end else if (do_write || load_tx) begin
            ptr <= step_ptr(ptr, wrap0, wrap1);
        end
    end

    // ==========================================================
    // register space; a link write wins over a sensor update to the same cell
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= REG_RESET;
            end
        end else begin
            if (upd_valid && !(do_write && upd_addr == ptr)) begin
                mem[upd_addr] <= upd_data;
            end
            if (do_write) begin
                mem[ptr] <= shreg;
            end
        end
    end

    // ==========================================================
    // chip-facing status, all registered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (start_seen) begin
            busy <= 1'b1;
        end else if (stop_seen) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pulse <= 1'b0;
            wr_addr <= REG_RESET;
            wr_data <= REG_RESET;
        end else begin
            wr_pulse <= do_write;
            if (do_write) begin
                wr_addr <= ptr;
                wr_data <= shreg;
            end
        end
    end

    // open drain: drive low only, clock is never touched
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = sda_oe;

endmodule

// ### verilog/i2c_host_end.sv
// Purpose: host end of the two-wire link, driven by commands written over APB
// Assumes: single client, no arbitration, no clock stretching from the client
// Notes: each command is one start, stop, byte write or byte read
module i2c_host_end
    import i2c_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link
    i2c_link_if.host link
);
    logic sda_s;
    logic busy;
    host_cmd_t cmd;
    logic nack_cfg;
    logic [7:0] txdata;
    logic [7:0] rxdata;
    logic nack_seen;
    logic [5:0] qcnt;
    logic qtick;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic scl_oe;
    logic sda_oe;
    logic acc;
    logic wr_now;
    logic mapped;

    pin_sync #(.W(1)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(link.sda),
        .level(sda_s)
    );

    // ==========================================================
    // apb: one wait state, effect and read data at the pready edge
    assign acc = psel && penable && !pready;
    assign wr_now = psel && penable && pready && pwrite;
    assign mapped = paddr == APB_CTRL || paddr == APB_TXDATA || paddr == APB_STATUS;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= acc;
            pslverr <= acc && !mapped;
            prdata <= '0;
            if (acc && !pwrite && paddr == APB_CTRL) begin
                prdata[CTRL_CMD_LSB +: 3] <= cmd;
                prdata[CTRL_NACK_BIT] <= nack_cfg;
            end else if (acc && !pwrite && paddr == APB_TXDATA) begin
                prdata[7:0] <= txdata;
            end else if (acc && !pwrite && paddr == APB_STATUS) begin
                prdata[STATUS_BUSY_BIT] <= busy;
                prdata[STATUS_NACK_BIT] <= nack_seen;
                prdata[STATUS_RX_LSB +: 8] <= rxdata;
            end
        end
    end

    // commands written while busy are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd <= cmd_none;
            nack_cfg <= 1'b0;
            txdata <= REG_RESET;
        end else if (wr_now && paddr == APB_CTRL && !busy) begin
            cmd <= host_cmd_t'(pwdata[CTRL_CMD_LSB +: 3]);
            nack_cfg <= pwdata[CTRL_NACK_BIT];
        end else if (wr_now && paddr == APB_TXDATA && !busy) begin
            txdata <= pwdata[7:0];
        end
    end

    // ==========================================================
    // quarter-period divider, runs only while a command is active
    always_ff @(posedge clk) begin
        if (!rst_n || !busy || qtick) begin
            qcnt <= QUARTER_RESET;
        end else begin
            qcnt <= 6'(qcnt + QUARTER_STEP);
        end
    end
    assign qtick = busy && qcnt == QUARTER_LAST;

    // ==========================================================
    // bit sequencer; the host makes every clock pulse, ninth included
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            phase <= PH_SETUP;
            bitn <= BIT_FIRST;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            nack_seen <= 1'b0;
            rxdata <= REG_RESET;
        end else if (!busy) begin
            phase <= PH_SETUP;
            bitn <= BIT_FIRST;
            busy <= wr_now && paddr == APB_CTRL && pwdata[CTRL_CMD_LSB +: 3] != cmd_none;
        end else if (qtick) begin
            phase <= 2'(phase + 2'h1);
            case (cmd)
                cmd_start: begin
                    // released data then a fall while clock is high
                    if (phase == PH_SETUP) sda_oe <= 1'b0;
                    if (phase == PH_RISE) scl_oe <= 1'b0;
                    if (phase == PH_HIGH) sda_oe <= 1'b1;
                    if (phase == PH_FALL) scl_oe <= 1'b1;
                    if (phase == PH_FALL) busy <= 1'b0;
                end
                cmd_stop: begin
                    if (phase == PH_SETUP) sda_oe <= 1'b1;
                    if (phase == PH_RISE) scl_oe <= 1'b0;
                    if (phase == PH_HIGH) sda_oe <= 1'b0;
                    if (phase == PH_FALL) busy <= 1'b0;
                end
                cmd_write, cmd_read: begin
                    if (phase == PH_SETUP) begin
                        // data set up only while the clock is low
                        if (cmd == cmd_write) begin
                            sda_oe <= (bitn < BIT_ACK) ? !txdata[3'(BIT_LAST_DATA - bitn)] : 1'b0;
                        end else begin
                            sda_oe <= (bitn < BIT_ACK) ? 1'b0 : !nack_cfg;
                        end
                    end
                    if (phase == PH_RISE) scl_oe <= 1'b0;
                    if (phase == PH_HIGH) begin
                        if (cmd == cmd_write && bitn == BIT_ACK) nack_seen <= sda_s;
                        if (cmd == cmd_read && bitn < BIT_ACK) rxdata <= {rxdata[6:0], sda_s};
                    end
                    if (phase == PH_FALL) begin
                        scl_oe <= 1'b1;
                        bitn <= 4'(bitn + BIT_STEP);
                        if (bitn == BIT_ACK) busy <= 1'b0;
                    end
                end
                default: busy <= 1'b0;
            endcase
        end
    end

    assign link.scl_host_o = 1'b0;
    assign link.scl_host_oe = scl_oe;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = sda_oe;

endmodule

// ### bench/i2c_link_chk.sv
// Purpose: wire and frame checks for the two-wire register link
// Assumes: one clock domain, synchronous active-low reset
// Notes: watches the resolved wires beside the interface, no bind
module i2c_link_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link wires and drivers
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_host_oe,
    input wire logic sda_dev_oe,
    // client status
    input wire logic busy,
    input wire logic wr_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // wire level rules
    dev_sda_edge_a: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("client moved sda while scl high");
    start_busy_a: assert property ($fell(sda) && scl |-> ##[1:6] busy)
        else $error("start not seen as busy");
    stop_free_a: assert property ($rose(sda) && scl |-> ##[1:6] !busy)
        else $error("stop did not free the bus");
    // a register write must land inside the low half of the ack pulse, no stretching needed
    ack_in_low_a: assert property (wr_pulse |-> !scl)
        else $error("register write outside the ack low phase");
    // the client only starts pulling sda while the host is holding scl low
    dev_drive_low_a: assert property ($rose(sda_dev_oe) |-> scl_host_oe)
        else $error("client pulled sda while host released scl");
    scl_pulse_a: assert property ($rose(scl) |-> scl [*8])
        else $error("scl pulse too short");
    // ==========================================================
    // frame rules, the client drives nothing outside a frame
    idle_release_a: assert property (!busy |-> !sda_dev_oe)
        else $error("client drives sda while idle");
    wr_in_frame_a: assert property (wr_pulse |-> busy)
        else $error("register write outside a frame");
    wr_single_a: assert property (wr_pulse |=> !wr_pulse)
        else $error("write pulse longer than a cycle");
endmodule

// ### bench/test_i2c_client_register_access.sv
// Purpose: drives the host end over APB and checks the client end across the link
// Assumes: both ends on one 20 MHz clock, wires resolved in the interface
// Notes: client registers are preloaded through the update port
module test_i2c_client_register_access import i2c_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, upd_valid = 1'b0;
    logic [7:0] paddr = 8'h00, upd_addr = 8'h00, upd_data = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, st;
    logic pready, busy, wr_pulse;
    logic [7:0] wr_addr, wr_data;
    logic [7:0] last_reg[4] = '{REG_LAST, REG_SENSOR0_HIGH, REG_SENSOR1_HIGH, REG_TIMESTAMP3};
    logic [7:0] wrap_reg[4] = '{REG_FIRST, REG_STATUS_COPY, REG_STATUS_COPY, REG_STATUS_COPY};
    int error_cnt = 0, compares = 0, cycles = 0;

    // ==========================================================
    // clock, ends and checker
    always #25 clk = ~clk;
    i2c_link_if i_i2c_link_if ();
    i2c_host_end i_i2c_host_end (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .link(i_i2c_link_if.host));
    i2c_client_end i_i2c_client_end (.clk(clk), .rst_n(rst_n), .link(i_i2c_link_if.device),
        .upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data), .busy(busy), .wr_pulse(wr_pulse),
        .wr_addr(wr_addr), .wr_data(wr_data));
    i2c_link_chk i_i2c_link_chk (.clk(clk), .rst_n(rst_n), .scl(i_i2c_link_if.scl), .sda(i_i2c_link_if.sda),
        .scl_host_oe(i_i2c_link_if.scl_host_oe), .sda_dev_oe(i_i2c_link_if.sda_dev_oe), .busy(busy),
        .wr_pulse(wr_pulse));

    // ==========================================================
    // tasks
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        st = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one host command, then poll status until idle
    task automatic cmd(input host_cmd_t c, input logic [7:0] tx, input logic nk);
        apb(1'b1, APB_TXDATA, {24'h0, tx});
        apb(1'b1, APB_CTRL, {28'h0, nk, c});
        st = 32'h1;
        while (st[STATUS_BUSY_BIT] !== 1'b0) apb(1'b0, APB_STATUS, 32'h0);
    endtask

    task automatic put(input logic [7:0] b);
        cmd(cmd_write, b, 1'b0);
    endtask

    // pointer write, restart, two reads, the last one refused by the host
    task automatic rd2(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
        cmd(cmd_start, 8'h00, 1'b0);
        put({CLIENT_ADDR, 1'b0});
        put(p);
        cmd(cmd_start, 8'h00, 1'b0);
        put({CLIENT_ADDR, 1'b1});
        cmd(cmd_read, 8'h00, 1'b0);
        `CHK("first read", e0, st[15:8])
        cmd(cmd_read, 8'h00, 1'b1);
        `CHK("second read", e1, st[15:8])
        cmd(cmd_stop, 8'h00, 1'b0);
    endtask

    // hang guard, a full run takes about 95000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 98000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // preload 00h, 61h..69h and ffh with a known pattern
        for (int i = 0; i <= 10; i++) begin
            upd_valid <= 1'b1;
            upd_addr <= (i == 0) ? 8'h00 : (i == 10) ? 8'hff : 8'(8'h60 + i);
            upd_data <= ((i == 0) ? 8'h00 : (i == 10) ? 8'hff : 8'(8'h60 + i)) ^ 8'h3c;
            @(posedge clk);
        end
        upd_valid <= 1'b0;
        cmd(cmd_start, 8'h00, 1'b0);
        put({CLIENT_ADDR, 1'b0});
        `CHK("address ack", 1'b0, st[STATUS_NACK_BIT])
        put(8'h10);
        put(8'ha5);
        put(8'h5a);
        `CHK("data ack", 1'b0, st[STATUS_NACK_BIT])
        cmd(cmd_stop, 8'h00, 1'b0);
        `CHK("busy", 1'b0, busy)
        `CHK("wr_addr", 8'h11, wr_addr)
        `CHK("wr_data", 8'h5a, wr_data)
        rd2(8'h10, 8'ha5, 8'h5a);
        $display("test write and read back done");
        // foreign address, restart, then a write into the read-only area
        cmd(cmd_start, 8'h00, 1'b0);
        put({CLIENT_ADDR ^ 7'h01, 1'b0});
        `CHK("foreign address", 1'b1, st[STATUS_NACK_BIT])
        cmd(cmd_start, 8'h00, 1'b0);
        put({CLIENT_ADDR, 1'b0});
        `CHK("restart ack", 1'b0, st[STATUS_NACK_BIT])
        put(REG_DSP_STATUS);
        put(8'h77);
        `CHK("read-only nack", 1'b1, st[STATUS_NACK_BIT])
        cmd(cmd_stop, 8'h00, 1'b0);
        `CHK("no write", 8'h11, wr_addr)
        $display("test refusals done");
        // every wrap mode, read the last cell and the one after it
        for (int m = 0; m < 4; m++) begin
            cmd(cmd_start, 8'h00, 1'b0);
            put({CLIENT_ADDR, 1'b0});
            put(REG_SOURCE_SELECT_A);
            put({m[0], 7'h00});
            put({m[1], 7'h00});
            cmd(cmd_stop, 8'h00, 1'b0);
            rd2(last_reg[m], last_reg[m] ^ 8'h3c, wrap_reg[m] ^ 8'h3c);
        end
        $display("test wrap modes done");
        stop_test();
    end
endmodule
